// ==== hw/hap_profile_cfg.v ====
// Hot-alert profile configuration registers, input filtering, deglitch and alert output
`timescale 1ns/1ns
`include "hap_map.vh"

// ----------------------------------------
// Overview of operation
// - Bits 7..2 of the first option register hold the system voltage level that starts bus discharge in supplement mode.
// - The nominal-current deglitch select gives about 0.988 ms when clear and 64 ms when set, default 0.
// - With the lowered-threshold enable at 0 the input-voltage alert uses the regular setting, at 1 the chosen ratio; default 1.
// - With the lowered threshold active, the ratio select gives 83 percent when 0 and 91 percent when 1, default 0.
// - The 5-bit peak current field in bits 7..3 decodes to a percentage of input limit, 00000b and 11111b out of range, default 9h.
// - The critical-current deglitch field selects 14.5, 111, 443 or 873 us, default 01b.
// - Enable bits 7..4 gate input-voltage, comparator, critical-current and nominal-current sources onto the alert.
// - Enable bits 3..0 gate discharge level one, system voltage, battery removal and adapter removal sources.
// - An enabled battery removal fires one single alert pulse at once.
// - An enabled adapter removal holds the alert output low.
// - The three option registers reset to 39h, 4Ah and A0h and are fully read-write.
// - A register-reset command returns the three option registers to their defaults.
// ----------------------------------------
module hap_profile_cfg #(
  parameter INOM0_CYC   = (`HAP_T_INOM0_NS + `HAP_CLK_NS - 1) / `HAP_CLK_NS,
  parameter INOM1_CYC   = (`HAP_T_INOM1_NS + `HAP_CLK_NS - 1) / `HAP_CLK_NS,
  parameter ICRIT1_CYC  = (`HAP_T_ICRIT1_NS + `HAP_CLK_NS - 1) / `HAP_CLK_NS,
  parameter ICRIT2_CYC  = (`HAP_T_ICRIT2_NS + `HAP_CLK_NS - 1) / `HAP_CLK_NS,
  parameter ICRIT3_CYC  = (`HAP_T_ICRIT3_NS + `HAP_CLK_NS - 1) / `HAP_CLK_NS,
  parameter CNT_W       = 24
) (
  input  wire       clock,              // System clock, 125 MHz
  input  wire       rst_n,              // Synchronous reset, active low
  input  wire [7:0] reg_addr,           // Register offset
  input  wire [7:0] reg_wdata,          // Write data
  input  wire       reg_wr,             // Write strobe, one cycle
  input  wire       reg_rd,             // Read strobe, one cycle
  input  wire       reg_reset_cmd,      // Register-reset command pulse
  output reg  [7:0] reg_rdata,          // Read data
  output reg        reg_rvalid,         // Read data valid pulse
  input  wire       vin_trip,           // Input-voltage comparator tripped
  input  wire       cmp_trip,           // Independent comparator tripped
  input  wire       critical_current_trigger_trip,         // Critical current above limit
  input  wire       nominal_current_trigger_trip,          // Nominal current above limit
  input  wire       idchg1_trip,        // Discharge level one tripped
  input  wire       vsys_trip,          // System voltage low
  input  wire       bat_present,        // Battery present level
  input  wire       adapter_ok,         // Adapter present level
  output reg  [5:0] sys_voltage_supplement_threshold, // Supplement-mode voltage level
  output reg  [1:0] vin_alert_thr_sel,  // Comparator threshold select
  output reg  [8:0] peak_current_pct,   // Peak input current threshold, percent
  output reg        peak_current_oor,   // Peak threshold code out of range
  output reg        hot_alert_out_n     // Hot alert to processor, active low
);

  // Kept unsized and cut to the counter width where used
  localparam ICRIT0_CYC = (`HAP_T_ICRIT0_NS + `HAP_CLK_NS - 1) / `HAP_CLK_NS;
  localparam BATP_CYC   = (`HAP_T_BATPULSE_NS + `HAP_CLK_NS - 1) / `HAP_CLK_NS;
  localparam NSRC = 8;
  localparam [NSRC-1:0] IN_IDLE = `HAP_IN_IDLE;

  reg  [7:0]       volt_deg_r;
  reg  [7:0]       peak_cur_r;
  reg  [7:0]       src_en_r;
  reg  [NSRC-1:0]  sync1_r;
  reg  [NSRC-1:0]  sync2_r;
  reg  [NSRC-1:0]  sync3_r;
  reg  [NSRC-1:0]  filt_r;
  reg  [CNT_W-1:0] nominal_current_trigger_cnt_r;
  reg  [CNT_W-1:0] critical_current_trigger_cnt_r;
  reg  [CNT_W-1:0] batp_cnt_r;
  reg              nominal_current_trigger_ok_r;
  reg              critical_current_trigger_ok_r;
  reg              bat_prev_r;
  reg  [CNT_W-1:0] nominal_current_trigger_tgt;
  reg  [CNT_W-1:0] critical_current_trigger_tgt;
  wire [NSRC-1:0]  raw_in;
  wire             alert_any;

  // Peak threshold code to percent of input current limit
  function [8:0] hap_peak_pct;
    input [4:0] code;
    begin
      case (code)
        5'h18:   hap_peak_pct = 9'h0E1;
        5'h19:   hap_peak_pct = 9'h0FA;
        5'h1A:   hap_peak_pct = 9'h113;
        5'h1B:   hap_peak_pct = 9'h12C;
        5'h1C:   hap_peak_pct = 9'h15E;
        5'h1D:   hap_peak_pct = 9'h190;
        5'h1E:   hap_peak_pct = 9'h1C2;
        5'h00:   hap_peak_pct = 9'h000;
        5'h1F:   hap_peak_pct = 9'h000;
        default: hap_peak_pct = 9'h069 + 9'h005 * {4'h0, code};
      endcase
    end
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------

  // Reset command beats a write in the same cycle
  always @(posedge clock) begin
    if (!rst_n || reg_reset_cmd) begin
      volt_deg_r <= `HAP_RST_VOLT_DEG;
      peak_cur_r <= `HAP_RST_PEAK_CUR;
      src_en_r   <= `HAP_RST_SRC_EN;
    end else if (reg_wr) begin
      case (reg_addr)
        `HAP_OFS_VOLT_DEG: volt_deg_r <= reg_wdata;
        `HAP_OFS_PEAK_CUR: peak_cur_r <= reg_wdata;
        `HAP_OFS_SRC_EN:   src_en_r   <= reg_wdata;
        default:           volt_deg_r <= volt_deg_r;
      endcase
    end
  end

  // Read port, unmapped offsets read zero
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      case (reg_addr)
        `HAP_OFS_VOLT_DEG: reg_rdata <= volt_deg_r;
        `HAP_OFS_PEAK_CUR: reg_rdata <= peak_cur_r;
        `HAP_OFS_SRC_EN:   reg_rdata <= src_en_r;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Input filtering
  // ----------------------------------------

  // Same bit order as the enable register, so the enable bit names index it
  assign raw_in = {vin_trip, cmp_trip, critical_current_trigger_trip, nominal_current_trigger_trip,
                   idchg1_trip, vsys_trip, bat_present, adapter_ok};

  // Three stages; a level is taken only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_sync
      always @(posedge clock) begin
        if (!rst_n) begin
          sync1_r[gi] <= IN_IDLE[gi];
          sync2_r[gi] <= IN_IDLE[gi];
          sync3_r[gi] <= IN_IDLE[gi];
          filt_r[gi]  <= IN_IDLE[gi]; // Idle levels: no false removal edge after reset
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi])
            filt_r[gi] <= sync3_r[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Deglitch timers
  // ----------------------------------------

  // Selected target counts
  always @* begin
    nominal_current_trigger_tgt = volt_deg_r[`HAP_NOMINAL_CURRENT_DEGLITCH_SEL_BIT] ? INOM1_CYC[CNT_W-1:0] : INOM0_CYC[CNT_W-1:0];
    case (peak_cur_r[`HAP_CRITICAL_CURRENT_DEGLITCH_SEL_HI:`HAP_CRITICAL_CURRENT_DEGLITCH_SEL_LO])
      2'h0:    critical_current_trigger_tgt = ICRIT0_CYC[CNT_W-1:0];
      2'h1:    critical_current_trigger_tgt = ICRIT1_CYC[CNT_W-1:0];
      2'h2:    critical_current_trigger_tgt = ICRIT2_CYC[CNT_W-1:0];
      default: critical_current_trigger_tgt = ICRIT3_CYC[CNT_W-1:0];
    endcase
  end

  // Counters restart whenever the condition drops or its profile is off
  always @(posedge clock) begin
    if (!rst_n) begin
      nominal_current_trigger_cnt_r  <= {CNT_W{1'b0}};
      critical_current_trigger_cnt_r <= {CNT_W{1'b0}};
      nominal_current_trigger_ok_r   <= 1'b0;
      critical_current_trigger_ok_r  <= 1'b0;
    end else begin
      if (!(filt_r[`HAP_EN_NOMINAL_CURRENT_TRIGGER_BIT] && src_en_r[`HAP_EN_NOMINAL_CURRENT_TRIGGER_BIT])) begin
        nominal_current_trigger_cnt_r <= {CNT_W{1'b0}};
        nominal_current_trigger_ok_r  <= 1'b0;
      end else if (nominal_current_trigger_cnt_r + 1'b1 >= nominal_current_trigger_tgt) begin
        nominal_current_trigger_ok_r  <= 1'b1;
      end else begin
        nominal_current_trigger_cnt_r <= nominal_current_trigger_cnt_r + 1'b1;
      end
      if (!(filt_r[`HAP_EN_CRITICAL_CURRENT_TRIGGER_BIT] && src_en_r[`HAP_EN_CRITICAL_CURRENT_TRIGGER_BIT])) begin
        critical_current_trigger_cnt_r <= {CNT_W{1'b0}};
        critical_current_trigger_ok_r  <= 1'b0;
      end else if (critical_current_trigger_cnt_r + 1'b1 >= critical_current_trigger_tgt) begin
        critical_current_trigger_ok_r  <= 1'b1;
      end else begin
        critical_current_trigger_cnt_r <= critical_current_trigger_cnt_r + 1'b1;
      end
    end
  end

  // Battery removal one-shot; a new removal restarts the pulse
  always @(posedge clock) begin
    if (!rst_n) begin
      bat_prev_r <= 1'b1;
      batp_cnt_r <= {CNT_W{1'b0}};
    end else begin
      bat_prev_r <= filt_r[`HAP_EN_BAT_BIT];
      if (bat_prev_r && !filt_r[`HAP_EN_BAT_BIT] && src_en_r[`HAP_EN_BAT_BIT])
        batp_cnt_r <= BATP_CYC[CNT_W-1:0];
      else if (batp_cnt_r != {CNT_W{1'b0}})
        batp_cnt_r <= batp_cnt_r - 1'b1;
    end
  end

  // ----------------------------------------
  // Alert combine and config outputs
  // ----------------------------------------

  assign alert_any =
    (filt_r[`HAP_EN_VIN_BIT] && src_en_r[`HAP_EN_VIN_BIT])     ||
    (filt_r[`HAP_EN_CMP_BIT] && src_en_r[`HAP_EN_CMP_BIT])     ||
    critical_current_trigger_ok_r || nominal_current_trigger_ok_r                                    ||
    (filt_r[`HAP_EN_IDCHG_BIT] && src_en_r[`HAP_EN_IDCHG_BIT]) ||
    (filt_r[`HAP_EN_VSYS_BIT] && src_en_r[`HAP_EN_VSYS_BIT])   ||
    (batp_cnt_r != {CNT_W{1'b0}})                              ||
    (!filt_r[`HAP_EN_AC_BIT] && src_en_r[`HAP_EN_AC_BIT]);

  // All outputs registered so the analog side sees clean levels
  always @(posedge clock) begin
    if (!rst_n) begin
      hot_alert_out_n                  <= 1'b1;
      sys_voltage_supplement_threshold <= 6'h00;
      vin_alert_thr_sel                <= `HAP_THR_REGULAR;
      peak_current_pct                 <= 9'h000;
      peak_current_oor                 <= 1'b0;
    end else begin
      hot_alert_out_n <= !alert_any;
      sys_voltage_supplement_threshold <= volt_deg_r[`HAP_VSYS_TH_HI:`HAP_VSYS_TH_LO];
      if (!volt_deg_r[`HAP_LOWER_EN_BIT])
        vin_alert_thr_sel <= `HAP_THR_REGULAR;
      else if (peak_cur_r[`HAP_RATIO_SEL_BIT])
        vin_alert_thr_sel <= `HAP_THR_91PCT;
      else
        vin_alert_thr_sel <= `HAP_THR_83PCT;
      peak_current_pct <= hap_peak_pct(peak_cur_r[`HAP_PEAK_TH_HI:`HAP_PEAK_TH_LO]);
      peak_current_oor <= (peak_cur_r[`HAP_PEAK_TH_HI:`HAP_PEAK_TH_LO] == `HAP_PEAK_OOR_LO) ||
                          (peak_cur_r[`HAP_PEAK_TH_HI:`HAP_PEAK_TH_LO] == `HAP_PEAK_OOR_HI);
    end
  end

endmodule

// ==== shared/hap_map.vh ====
// Address map, field layout, defaults and timing figures of the hot-alert profile registers
`ifndef HAP_MAP_VH
`define HAP_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HAP_OFS_VOLT_DEG    8'h36
`define HAP_OFS_PEAK_CUR    8'h37
`define HAP_OFS_SRC_EN      8'h38

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HAP_RST_VOLT_DEG    8'h39
`define HAP_RST_PEAK_CUR    8'h4A
`define HAP_RST_SRC_EN      8'hA0

// ----------------------------------------
// Fields of the voltage/deglitch register
// ----------------------------------------
`define HAP_VSYS_TH_HI      7
`define HAP_VSYS_TH_LO      2
`define HAP_NOMINAL_CURRENT_DEGLITCH_SEL_BIT    1
`define HAP_LOWER_EN_BIT    0

// ----------------------------------------
// Fields of the peak-current register
// ----------------------------------------
`define HAP_PEAK_TH_HI      7
`define HAP_PEAK_TH_LO      3
`define HAP_CRITICAL_CURRENT_DEGLITCH_SEL_HI    2
`define HAP_CRITICAL_CURRENT_DEGLITCH_SEL_LO    1
`define HAP_RATIO_SEL_BIT   0

// ----------------------------------------
// Fields of the source enable register
// ----------------------------------------
`define HAP_EN_VIN_BIT      7
`define HAP_EN_CMP_BIT      6
`define HAP_EN_CRITICAL_CURRENT_TRIGGER_BIT    5
`define HAP_EN_NOMINAL_CURRENT_TRIGGER_BIT     4
`define HAP_EN_IDCHG_BIT    3
`define HAP_EN_VSYS_BIT     2
`define HAP_EN_BAT_BIT      1
`define HAP_EN_AC_BIT       0

// ----------------------------------------
// Idle levels of the inputs: battery and adapter present
// ----------------------------------------
`define HAP_IN_IDLE         8'h03

// ----------------------------------------
// Comparator threshold select codes
// ----------------------------------------
`define HAP_THR_REGULAR     2'h0
`define HAP_THR_83PCT       2'h1
`define HAP_THR_91PCT       2'h2

// ----------------------------------------
// Peak threshold out-of-range codes
// ----------------------------------------
`define HAP_PEAK_OOR_LO     5'h00
`define HAP_PEAK_OOR_HI     5'h1F

// ----------------------------------------
// Timing, in ns, and clock period
// ----------------------------------------
`define HAP_CLK_NS          8
`define HAP_T_INOM0_NS      988000
`define HAP_T_INOM1_NS      64000000
`define HAP_T_ICRIT0_NS     14500
`define HAP_T_ICRIT1_NS     111000
`define HAP_T_ICRIT2_NS     443000
`define HAP_T_ICRIT3_NS     873000
`define HAP_T_BATPULSE_NS   10000

`endif

// ==== verif/hap_profile_cfg_properties.sv ====
// Checker of the hot-alert profile register block, bound to its ports
`timescale 1ns/1ns
module hap_profile_cfg_chk (
  input wire logic       clock,                            // System clock
  input wire logic       rst_n,                            // Reset, active low
  input wire logic [7:0] reg_addr,                         // Offset
  input wire logic [7:0] reg_wdata,                        // Write data
  input wire logic       reg_wr,                           // Write strobe
  input wire logic       reg_rd,                           // Read strobe
  input wire logic       reg_reset_cmd,                    // Register reset
  input wire logic [7:0] reg_rdata,                        // Read data
  input wire logic       reg_rvalid,                       // Read valid
  input wire logic       vin_trip,                         // Input voltage
  input wire logic       cmp_trip,                         // Comparator
  input wire logic       critical_current_trigger_trip,                       // Critical current
  input wire logic       nominal_current_trigger_trip,                        // Nominal current
  input wire logic       idchg1_trip,                      // Discharge one
  input wire logic       vsys_trip,                        // System voltage
  input wire logic       bat_present,                      // Battery level
  input wire logic       adapter_ok,                       // Adapter level
  input wire logic [5:0] sys_voltage_supplement_threshold, // Supplement level
  input wire logic [1:0] vin_alert_thr_sel,                // Threshold select
  input wire logic [8:0] peak_current_pct,                 // Peak percent
  input wire logic       peak_current_oor,                 // Out of range
  input wire logic       hot_alert_out_n                   // Alert, active low
);
  // No source asks for an alert
  wire quiet = !(vin_trip | cmp_trip | critical_current_trigger_trip | nominal_current_trigger_trip | idchg1_trip | vsys_trip | !bat_present | !adapter_ok);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Register path
  // ----------------------------------------
  read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("valid without read");
  unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h36 || reg_addr > 8'h38) |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  supply_thr_write_a: assert property (reg_wr && reg_addr == 8'h36 && !reg_reset_cmd ##1 !reg_wr && !reg_reset_cmd
    |=> sys_voltage_supplement_threshold == $past(reg_wdata[7:2], 2)) else $error("threshold not written");
  reset_cmd_default_a: assert property (reg_reset_cmd ##1 !reg_wr |=> sys_voltage_supplement_threshold == 6'h0E
    && vin_alert_thr_sel == 2'h1 && peak_current_pct == 9'h096) else $error("defaults not restored");
  oor_pct_zero_a: assert property (peak_current_oor |-> peak_current_pct == 9'h000) else $error("oor pct");
  thr_sel_legal_a: assert property (vin_alert_thr_sel != 2'h3) else $error("bad threshold select");

  // ----------------------------------------
  // Alert output
  // ----------------------------------------
  alert_fall_cause_a: assert property ($fell(hot_alert_out_n) |-> $past(!quiet, 3))
    else $error("alert without source");
  quiet_release_a: assert property (quiet [*8] |-> hot_alert_out_n) else $error("alert held while quiet");

  cover property ($fell(hot_alert_out_n));
  cover property (reg_reset_cmd);
  cover property (peak_current_oor);
endmodule

bind hap_profile_cfg hap_profile_cfg_chk i_chk (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_reset_cmd(reg_reset_cmd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .vin_trip(vin_trip),
  .cmp_trip(cmp_trip), .critical_current_trigger_trip(critical_current_trigger_trip), .nominal_current_trigger_trip(nominal_current_trigger_trip), .idchg1_trip(idchg1_trip),
  .vsys_trip(vsys_trip), .bat_present(bat_present), .adapter_ok(adapter_ok),
  .sys_voltage_supplement_threshold(sys_voltage_supplement_threshold), .vin_alert_thr_sel(vin_alert_thr_sel),
  .peak_current_pct(peak_current_pct), .peak_current_oor(peak_current_oor), .hot_alert_out_n(hot_alert_out_n));

// ==== verif/hap_host_model.sv ====
// Host-side model that times the hot-alert pulses it receives
`timescale 1ns/1ns
module hap_host_model (
  input  wire logic clock,   // System clock
  input  wire logic rst_n,   // Reset, active low
  input  wire logic alert_n, // Hot alert, active low
  output int        width    // Last low width in cycles
);
  int cnt;

  // Count low cycles; a rise closes the pulse
  always @(posedge clock) begin
    if (!rst_n) begin
      cnt <= 0;
      width <= 0;
    end else if (!alert_n) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      width <= cnt;
      cnt <= 0;
    end
  end
endmodule

// ==== verif/hap_profile_cfg_test.sv ====
// Self-checking bench for the hot-alert profile registers
`timescale 1ns/1ns
module hap_profile_cfg_test;
  logic       clock, rst_n, reg_wr, reg_rd, reg_reset_cmd;
  logic [7:0] reg_addr, reg_wdata, src, reg_rdata;
  logic       reg_rvalid, oor, out_n;
  logic [5:0] thr;
  logic [1:0] sel;
  logic [8:0] pct;
  int         n_errors, num_checks, width;
  int         lat [4] = '{1813, 10, 15, 20};

  // Short deglitch counts keep the run brief
  hap_profile_cfg #(.INOM0_CYC(20), .INOM1_CYC(40), .ICRIT1_CYC(10), .ICRIT2_CYC(15), .ICRIT3_CYC(20)) i_dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_reset_cmd(reg_reset_cmd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .vin_trip(src[7]),
    .cmp_trip(src[6]), .critical_current_trigger_trip(src[5]), .nominal_current_trigger_trip(src[4]), .idchg1_trip(src[3]), .vsys_trip(src[2]),
    .bat_present(!src[1]), .adapter_ok(!src[0]), .sys_voltage_supplement_threshold(thr),
    .vin_alert_thr_sel(sel), .peak_current_pct(pct), .peak_current_oor(oor), .hot_alert_out_n(out_n));
  hap_host_model i_host (.clock(clock), .rst_n(rst_n), .alert_n(out_n), .width(width));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task print_verdict;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid, 1);
    chk(reg_rdata, exp);
  endtask
  task settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  // Raise one source, time the alert, drop it unless it is the battery source, and wait for release
  task probe(input logic [7:0] en, input int b, lo, hi, input logic hit);
    int n;
    wr(8'h38, en);
    @(posedge clock);
    src[b] <= 1'b1;
    for (n = 0; n < hi && out_n !== 1'b0; n++) begin
      @(posedge clock);
      #1;
    end
    chk(out_n, !hit);
    if (hit) chk(n >= lo, 1);
    if (out_n !== !hit) print_verdict;
    @(posedge clock);
    if (b != 1) src[b] <= 1'b0;
    for (n = 0; n < (b == 1 ? 1300 : 10) && out_n !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    chk(out_n, 1);
    if (out_n !== 1'b1) print_verdict;
    @(posedge clock);
    src <= 8'h00;
    repeat (8) @(posedge clock);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task reset_values;
    rd(8'h36, 8'h39);
    rd(8'h37, 8'h4A);
    rd(8'h38, 8'hA0);
    rd(8'h40, 8'h00);
    chk(thr, 6'h0E);
    chk(sel, 2'h1);
    chk(pct, 9'h096);
  endtask
  task fields;
    wr(8'h36, 8'hFC);
    wr(8'h37, 8'h09);
    settle;
    chk(thr, 6'h3F);
    chk(sel, 2'h0);
    chk(pct, 9'h06E);
    chk(oor, 0);
    wr(8'h36, 8'h01);
    settle;
    chk(sel, 2'h2);
    wr(8'h37, 8'h10);
    settle;
    chk(pct, 9'h073);
    chk(sel, 2'h1);
    wr(8'h37, 8'hF8);
    settle;
    chk(oor, 1);
    wr(8'h37, 8'hC0);
    settle;
    chk(pct, 9'h0E1);
    wr(8'h37, 8'h00);
    wr(8'h36, 8'h39);
    settle;
    chk(pct, 9'h000);
    chk(oor, 1);
    rd(8'h37, 8'h00);
  endtask
  task sources;
    probe(8'hA0, 7, 2, 8, 1);
    probe(8'hA0, 6, 0, 10, 0);
    probe(8'h40, 6, 2, 8, 1);
    probe(8'h08, 3, 2, 8, 1);
    probe(8'h04, 2, 2, 8, 1);
    probe(8'h01, 0, 2, 8, 1);
    probe(8'h02, 1, 2, 1300, 1);
    chk(width, 1250);
  endtask
  // Every critical code, then both nominal selects
  task deglitch;
    for (int k = 0; k < 4; k++) begin
      wr(8'h37, {5'h09, k[1:0], 1'b0});
      probe(8'h20, 5, lat[k], lat[k] + 8, 1);
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h36, {6'h0E, k[0], 1'b1});
      probe(8'h10, 4, 20 * (k + 1), 20 * (k + 1) + 8, 1);
    end
  endtask
  task reset_cmd;
    wr(8'h36, 8'h00);
    wr(8'h38, 8'hFF);
    @(posedge clock);
    reg_reset_cmd <= 1'b1;
    @(posedge clock);
    reg_reset_cmd <= 1'b0;
    rd(8'h36, 8'h39);
    rd(8'h37, 8'h4A);
    rd(8'h38, 8'hA0);
  endtask

  // ----------------------------------------
  // Clock and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_reset_cmd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    src = 8'h00;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    reset_values;
    fields;
    sources;
    deglitch;
    reset_cmd;
    print_verdict;
  end
endmodule
